// *** bench/tmrctl_testbench.sv ***
// Self-checking bench for the timer and external interrupt control register
`timescale 1ns/1ps
`include "tmrctl_defines.svh"
module testbench;
  import tmrctl_pkg::*;
  logic       ref_clk, rstn, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata;
  wire  [7:0] sfr_rdata_q;
  logic       timer_a_rollover, timer_b_rollover, timer_a_high_byte_rollover;
  logic       timer_a_split_mode, timer_a_irq_enable, timer_b_irq_enable;
  logic       vector_timer_a, vector_timer_b, vector_ext_a, vector_ext_b;
  logic       ext_irq_a_input, ext_irq_b_input, ext_irq_a_polarity, ext_irq_b_polarity;
  logic       timer_a_gate_enable;
  wire        timer_a_count_enable_q, timer_b_run_q, timer_a_high_byte_run_q;
  wire        timer_a_irq_q, timer_b_irq_q, ext_irq_a_flag_q, ext_irq_b_flag_q;
  int         miscompares, cmp_count, cyc;

  tmrctl_top i_tmrctl_top (.ref_clk, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .sfr_rdata_q, .timer_a_rollover, .timer_b_rollover, .timer_a_high_byte_rollover,
    .timer_a_split_mode, .timer_a_irq_enable, .timer_b_irq_enable, .vector_timer_a,
    .vector_timer_b, .vector_ext_a, .vector_ext_b, .ext_irq_a_input, .ext_irq_b_input,
    .ext_irq_a_polarity, .ext_irq_b_polarity, .timer_a_gate_enable,
    .timer_a_count_enable_q, .timer_b_run_q, .timer_a_high_byte_run_q, .timer_a_irq_q,
    .timer_b_irq_q, .ext_irq_a_flag_q, .ext_irq_b_flag_q);

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  // Hang guard, far above the fewer than one hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Every drive lands 1 ns after an edge, clear of the sampling instant
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic cmp8(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(logic got, logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask

  // One write strobe, held exactly one cycle
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
  endtask

  // Read data is registered, so it is judged right after the sampling edge
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    sfr_addr = a; sfr_rd = 1'b1;
    tick(1);
    sfr_rd = 1'b0;
    cmp8(sfr_rdata_q, exp);
  endtask

  task automatic t_run_gate();
    wr(`TMRCTL_ADDR, 8'h50);
    tick(1);
    cmp1(timer_a_count_enable_q, 1'b1);
    cmp1(timer_b_run_q, 1'b1);
    rd(`TMRCTL_ADDR, 8'h50);
    timer_a_gate_enable = 1'b1;
    tick(2);
    cmp1(timer_a_count_enable_q, 1'b0);
    ext_irq_a_input = 1'b1;
    tick(4);
    cmp1(timer_a_count_enable_q, 1'b1);
    cmp1(ext_irq_a_flag_q, 1'b1);
    ext_irq_a_input = 1'b0;
    tick(4);
    cmp1(ext_irq_a_flag_q, 1'b0);
    $display("test run_gate done");
  endtask

  task automatic t_overflow();
    timer_b_rollover = 1'b1; tick(1); timer_b_rollover = 1'b0;
    tick(1);
    cmp1(timer_b_irq_q, 1'b1);
    rd(`TMRCTL_ADDR, 8'hD0);
    vector_timer_b = 1'b1; tick(1); vector_timer_b = 1'b0;
    tick(1);
    cmp1(timer_b_irq_q, 1'b0);
    timer_a_irq_enable = 1'b0;
    timer_a_rollover = 1'b1; tick(1); timer_a_rollover = 1'b0;
    rd(`TMRCTL_ADDR, 8'h70);
    cmp1(timer_a_irq_q, 1'b0);
    timer_a_irq_enable = 1'b1;
    tick(2);
    cmp1(timer_a_irq_q, 1'b1);
    wr(`TMRCTL_ADDR, 8'h50);
    rd(`TMRCTL_ADDR, 8'h50);
    // Set timer A flag again, then clear it by vectoring
    timer_a_rollover = 1'b1; tick(1); timer_a_rollover = 1'b0;
    vector_timer_a = 1'b1; tick(1); vector_timer_a = 1'b0;
    cmp1(timer_a_irq_q, 1'b1);
    rd(`TMRCTL_ADDR, 8'h50);
    cmp1(timer_a_irq_q, 1'b0);
    $display("test overflow done");
  endtask

  task automatic t_split();
    timer_a_split_mode = 1'b1;
    tick(2);
    cmp1(timer_b_run_q, 1'b0);
    cmp1(timer_a_high_byte_run_q, 1'b1);
    timer_b_rollover = 1'b1; tick(1); timer_b_rollover = 1'b0;
    rd(`TMRCTL_ADDR, 8'h50);
    timer_a_high_byte_rollover = 1'b1; tick(1); timer_a_high_byte_rollover = 1'b0;
    rd(`TMRCTL_ADDR, 8'hD0);
    wr(`TMRCTL_ADDR, 8'h50);
    timer_a_split_mode = 1'b0;
    $display("test split done");
  endtask

  // Interrupt B is active low here, so polarity is exercised too
  task automatic t_ext_b();
    tick(1);
    wr(`TMRCTL_ADDR, 8'h54);
    ext_irq_b_input = 1'b0;
    tick(4);
    ext_irq_b_input = 1'b1;
    tick(4);
    cmp1(ext_irq_b_flag_q, 1'b1);
    rd(`TMRCTL_ADDR, 8'h5C);
    vector_ext_b = 1'b1; tick(1); vector_ext_b = 1'b0;
    tick(4);
    cmp1(ext_irq_b_flag_q, 1'b0);
    wr(`TMRCTL_ADDR, 8'h50);
    ext_irq_b_input = 1'b0;
    tick(4);
    cmp1(ext_irq_b_flag_q, 1'b1);
    ext_irq_b_input = 1'b1;
    tick(4);
    cmp1(ext_irq_b_flag_q, 1'b0);
    wr(8'h89, 8'hFF);
    rd(8'h89, 8'h00);
    tick(1);
    rd(`TMRCTL_ADDR, 8'h50);
    $display("test ext_b done");
  endtask

  // Interrupt A in edge mode: software clear, vector clear, written 1 ignored
  task automatic t_ext_a();
    wr(`TMRCTL_ADDR, 8'h51);
    ext_irq_a_input = 1'b1;
    tick(3);
    cmp1(ext_irq_a_flag_q, 1'b1);
    wr(`TMRCTL_ADDR, 8'h51);
    tick(2);
    cmp1(ext_irq_a_flag_q, 1'b0);
    ext_irq_a_input = 1'b0;
    tick(1);
    ext_irq_a_input = 1'b1;
    tick(2);
    cmp1(ext_irq_a_flag_q, 1'b1);
    rd(`TMRCTL_ADDR, 8'h53);
    vector_ext_a = 1'b1; tick(1); vector_ext_a = 1'b0;
    tick(1);
    cmp1(ext_irq_a_flag_q, 1'b0);
    wr(`TMRCTL_ADDR, 8'h53);
    rd(`TMRCTL_ADDR, 8'h51);
    $display("test ext_a done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    {ref_clk, rstn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    {timer_a_rollover, timer_b_rollover, timer_a_high_byte_rollover} = '0;
    {timer_a_split_mode, timer_a_irq_enable, timer_b_irq_enable} = '0;
    {vector_timer_a, vector_timer_b, vector_ext_a, vector_ext_b} = '0;
    {ext_irq_a_input, ext_irq_a_polarity, ext_irq_b_polarity} = 3'b010;
    ext_irq_b_input = 1'b1;
    timer_a_gate_enable = 1'b0;
    timer_b_irq_enable = 1'b1;
    miscompares = 0; cmp_count = 0; cyc = 0;
    tick(3);
    rstn = 1'b1;
    rd(`TMRCTL_ADDR, 8'h00);
    cmp1(timer_b_irq_q, 1'b0);
    t_run_gate();
    t_overflow();
    t_split();
    t_ext_b();
    t_ext_a();
    report_and_stop();
  end
endmodule // testbench

// *** core/tmrctl_ext_irq.sv ***
// External interrupt detector: polarity, edge or level, flag with vector clear
`timescale 1ns/1ps
`include "tmrctl_defines.svh"
module tmrctl_ext_irq
  import tmrctl_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // Input pin and configuration
  input  wire logic irq_input,
  input  wire logic irq_polarity,
  input  wire logic edge_select,
  // Clears
  input  wire logic sw_clear,
  input  wire logic vector_ack,
  // Flag
  output logic      flag_q
);
  logic           active;
  tmrctl_det_type det_q;

  // Pin is treated as synchronous; polarity high means active high
  assign active = (irq_input == irq_polarity);

  // Previous-level tracker for edge detection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      det_q <= TMRCTL_DET_IDLE;
    end else begin
      det_q <= active ? TMRCTL_DET_ACTIVE : TMRCTL_DET_IDLE;
    end
  end

  // Edge mode sticky, set beats clear; level mode follows input
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (!edge_select) begin
      flag_q <= active; // R08
    end else if (active && det_q == TMRCTL_DET_IDLE) begin
      flag_q <= 1'b1; // R08
    end else if (sw_clear || vector_ack) begin
      flag_q <= 1'b0; // R08
    end
  end

  // Skip the first edge after reset: the flag was forced low whatever the pin did
  AST_LEVEL_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rstn) // R08
    (!edge_select && $past(!edge_select) && $past(rstn)) |-> flag_q == $past(active))
    else $error("level flag does not follow input");
  AST_EDGE_SETS: assert property (@(posedge ref_clk) disable iff (!rstn) // R08
    (edge_select && active && det_q == TMRCTL_DET_IDLE) |=> flag_q)
    else $error("edge not latched");
endmodule // tmrctl_ext_irq

// *** core/tmrctl_top.sv ***
// Timer and external interrupt control register with flag logic
`timescale 1ns/1ps
`include "tmrctl_defines.svh"
// Overview of operation
// R01 - Bit 7 reads timer B overflow; stays 1 until cleared.
// R02 - Hardware sets timer B overflow on its rollover, except in split mode.
// R03 - Overflow flags clear by software write or by vectoring to their routine.
// R04 - Bit 2 picks level (0) or edge (1) detection for interrupt B.
// R05 - Timer A runs when run bit set and gate off or input active.
// R06 - Timer A overflow at bit 5 set on rollover; requests interrupt if enabled.
// R07 - In split mode, high byte overflow sets timer B flag, run by B's run bit.
// R08 - Interrupt flag latches edges, clears on vector; level mode follows input.
module tmrctl_top
  import tmrctl_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Special-function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata_q,
  // Timer events
  input  wire logic       timer_a_rollover,
  input  wire logic       timer_b_rollover,
  input  wire logic       timer_a_high_byte_rollover,
  input  wire logic       timer_a_split_mode,
  // Interrupt enables and vectoring
  input  wire logic       timer_a_irq_enable,
  input  wire logic       timer_b_irq_enable,
  input  wire logic       vector_timer_a,
  input  wire logic       vector_timer_b,
  input  wire logic       vector_ext_a,
  input  wire logic       vector_ext_b,
  // External interrupt pins and polarity config
  input  wire logic       ext_irq_a_input,
  input  wire logic       ext_irq_b_input,
  input  wire logic       ext_irq_a_polarity,
  input  wire logic       ext_irq_b_polarity,
  input  wire logic       timer_a_gate_enable,
  // Control outputs
  output logic            timer_a_count_enable_q,
  output logic            timer_b_run_q,
  output logic            timer_a_high_byte_run_q,
  output logic            timer_a_irq_q,
  output logic            timer_b_irq_q,
  output logic            ext_irq_a_flag_q,
  output logic            ext_irq_b_flag_q
);
  logic sel;
  logic wr;
  logic timer_b_overflow_flag;
  logic timer_a_overflow_flag;
  logic timer_a_run_control;
  logic timer_b_run_control;
  logic ext_irq_a_edge_select;
  logic ext_irq_b_edge_select;
  logic ext_a_flag;
  logic ext_b_flag;
  logic b_set;
  logic ext_a_active;

  // Address decode used by both read and write
  function automatic logic tmrctl_hit(input logic [7:0] a);
    return a == `TMRCTL_ADDR;
  endfunction

  assign sel = tmrctl_hit(sfr_addr);
  assign wr  = sfr_wr && sel;
  // Split mode steals timer B's flag for the high byte
  assign b_set = timer_a_split_mode ? timer_a_high_byte_rollover : timer_b_rollover; // R07

  // Timer B overflow flag; set wins over any clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_b_overflow_flag <= 1'b0;
    end else if (b_set) begin
      timer_b_overflow_flag <= 1'b1; // R02
    end else if (vector_timer_b) begin
      timer_b_overflow_flag <= 1'b0; // R03
    end else if (wr) begin
      timer_b_overflow_flag <= sfr_wdata[`TMRCTL_B_OVF_BIT]; // R03
    end
  end

  // Timer A overflow flag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_a_overflow_flag <= 1'b0;
    end else if (timer_a_rollover) begin
      timer_a_overflow_flag <= 1'b1; // R06
    end else if (vector_timer_a) begin
      timer_a_overflow_flag <= 1'b0; // R03
    end else if (wr) begin
      timer_a_overflow_flag <= sfr_wdata[`TMRCTL_A_OVF_BIT]; // R03
    end
  end

  // Software-only control bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_b_run_control   <= 1'b0;
      timer_a_run_control   <= 1'b0;
      ext_irq_b_edge_select <= 1'b0;
      ext_irq_a_edge_select <= 1'b0;
    end else if (wr) begin
      timer_b_run_control   <= sfr_wdata[`TMRCTL_B_RUN_BIT];
      timer_a_run_control   <= sfr_wdata[`TMRCTL_A_RUN_BIT];
      ext_irq_b_edge_select <= sfr_wdata[`TMRCTL_XB_EDGE_BIT]; // R04
      ext_irq_a_edge_select <= sfr_wdata[`TMRCTL_XA_EDGE_BIT];
    end
  end

  // Interrupt B detector; a written 0 to the flag acts as clear
  tmrctl_ext_irq u_ext_b (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .irq_input    (ext_irq_b_input),
    .irq_polarity (ext_irq_b_polarity),
    .edge_select  (ext_irq_b_edge_select), // R04
    .sw_clear     (wr && !sfr_wdata[`TMRCTL_XB_FLAG_BIT]),
    .vector_ack   (vector_ext_b),
    .flag_q       (ext_b_flag)
  );

  // Interrupt A detector
  tmrctl_ext_irq u_ext_a (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .irq_input    (ext_irq_a_input),
    .irq_polarity (ext_irq_a_polarity),
    .edge_select  (ext_irq_a_edge_select),
    .sw_clear     (wr && !sfr_wdata[`TMRCTL_XA_FLAG_BIT]),
    .vector_ack   (vector_ext_a),
    .flag_q       (ext_a_flag)
  );

  assign ext_a_active = (ext_irq_a_input == ext_irq_a_polarity);

  // Registered outputs; one cycle behind the stored bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_a_count_enable_q  <= 1'b0;
      timer_b_run_q           <= 1'b0;
      timer_a_high_byte_run_q <= 1'b0;
      timer_a_irq_q           <= 1'b0;
      timer_b_irq_q           <= 1'b0;
      ext_irq_a_flag_q        <= 1'b0;
      ext_irq_b_flag_q        <= 1'b0;
    end else begin
      timer_a_count_enable_q  <= timer_a_run_control
                                 && (!timer_a_gate_enable || ext_a_active); // R05
      // Timer B idles in split mode; its run bit drives the high byte instead
      timer_b_run_q           <= timer_b_run_control && !timer_a_split_mode;
      timer_a_high_byte_run_q <= timer_b_run_control && timer_a_split_mode; // R07
      timer_a_irq_q           <= timer_a_overflow_flag && timer_a_irq_enable; // R06
      timer_b_irq_q           <= timer_b_overflow_flag && timer_b_irq_enable;
      ext_irq_a_flag_q        <= ext_a_flag;
      ext_irq_b_flag_q        <= ext_b_flag;
    end
  end

  // Read data, registered; other addresses read zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata_q <= `TMRCTL_RESET;
    end else if (sfr_rd && sel) begin
      sfr_rdata_q <= {timer_b_overflow_flag, timer_b_run_control, // R01
                      timer_a_overflow_flag, timer_a_run_control,
                      ext_b_flag, ext_irq_b_edge_select,
                      ext_a_flag, ext_irq_a_edge_select};
    end else begin
      sfr_rdata_q <= 8'h00;
    end
  end

  AST_B_SET: assert property (@(posedge ref_clk) disable iff (!rstn) // R02
    b_set |=> timer_b_overflow_flag)
    else $error("timer B flag not set");
  AST_B_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn) // R01
    (timer_b_overflow_flag && !vector_timer_b && !wr) |=> timer_b_overflow_flag)
    else $error("timer B flag lost");
  AST_A_SET: assert property (@(posedge ref_clk) disable iff (!rstn) // R06
    timer_a_rollover |=> timer_a_overflow_flag)
    else $error("timer A flag not set");
  AST_VEC_CLR: assert property (@(posedge ref_clk) disable iff (!rstn) // R03
    (vector_timer_a && !timer_a_rollover) |=> !timer_a_overflow_flag)
    else $error("timer A flag not cleared on vector");
  AST_SW_CLR: assert property (@(posedge ref_clk) disable iff (!rstn) // R03
    (wr && !sfr_wdata[`TMRCTL_B_OVF_BIT] && !b_set) |=> !timer_b_overflow_flag)
    else $error("timer B flag not cleared by write");
  AST_EDGE_SEL: assert property (@(posedge ref_clk) disable iff (!rstn) // R04
    wr |=> ext_irq_b_edge_select == $past(sfr_wdata[`TMRCTL_XB_EDGE_BIT]))
    else $error("edge select not stored");
  AST_GATE: assert property (@(posedge ref_clk) disable iff (!rstn) // R05
    (timer_a_run_control && !timer_a_gate_enable) |=> timer_a_count_enable_q)
    else $error("timer A not enabled");
  AST_SPLIT: assert property (@(posedge ref_clk) disable iff (!rstn) // R07
    (timer_a_split_mode && timer_a_high_byte_rollover) |=> timer_b_overflow_flag)
    else $error("high byte overflow not flagged");
  AST_IRQ_A: assert property (@(posedge ref_clk) disable iff (!rstn) // R06
    (timer_a_rollover ##1 timer_a_irq_enable) |=> timer_a_irq_q)
    else $error("timer A irq missing");
  AST_READ: assert property (@(posedge ref_clk) disable iff (!rstn) // R01
    (sfr_rd && sel) |=> sfr_rdata_q[`TMRCTL_B_OVF_BIT] == $past(timer_b_overflow_flag))
    else $error("bit 7 read wrong");

  // Vectoring, idle read data, output copies and the run outputs
  AST_B_VEC_CLR: assert property (@(posedge ref_clk) disable iff (!rstn) // R03
    (vector_timer_b && !b_set) |=> !timer_b_overflow_flag)
    else $error("timer B flag not cleared on vector");
  AST_B_IRQ: assert property (@(posedge ref_clk) disable iff (!rstn) // R02
    (timer_b_overflow_flag && timer_b_irq_enable) |=> timer_b_irq_q)
    else $error("timer B irq missing");
  AST_IDLE_READ: assert property (@(posedge ref_clk) disable iff (!rstn) // R01
    !(sfr_rd && sel) |=> sfr_rdata_q == 8'h00)
    else $error("read data not zero when idle");
  AST_SPLIT_RUN: assert property (@(posedge ref_clk) disable iff (!rstn) // R07
    (timer_a_split_mode && timer_b_run_control) |=> (timer_a_high_byte_run_q && !timer_b_run_q))
    else $error("split run routing wrong");
  AST_GATE_OFF: assert property (@(posedge ref_clk) disable iff (!rstn) // R05
    (timer_a_gate_enable && !ext_a_active) |=> !timer_a_count_enable_q)
    else $error("timer A counts with gate closed");
  AST_EXT_COPY: assert property (@(posedge ref_clk) disable iff (!rstn) // R08
    1'b1 |=> ext_irq_a_flag_q == $past(ext_a_flag))
    else $error("interrupt A flag output wrong");
endmodule // tmrctl_top

// *** shared/tmrctl_defines.svh ***
// Offsets, field positions, reset value and timing constants of the timer control register
`ifndef TMRCTL_DEFINES_SVH
`define TMRCTL_DEFINES_SVH
`define TMRCTL_ADDR        8'h88
`define TMRCTL_RESET       8'h00
`define TMRCTL_B_OVF_BIT   7
`define TMRCTL_B_RUN_BIT   6
`define TMRCTL_A_OVF_BIT   5
`define TMRCTL_A_RUN_BIT   4
`define TMRCTL_XB_FLAG_BIT 3
`define TMRCTL_XB_EDGE_BIT 2
`define TMRCTL_XA_FLAG_BIT 1
`define TMRCTL_XA_EDGE_BIT 0
`define TMRCTL_SYNC_STAGES 2
`endif

// *** shared/tmrctl_pkg.sv ***
// Types shared by the timer control register files
package tmrctl_pkg;
  typedef enum logic [1:0] {
    TMRCTL_DET_IDLE,
    TMRCTL_DET_ACTIVE
  } tmrctl_det_type;
endpackage
